//--- margin_dac_map.vh
`ifndef MARGIN_DAC_MAP_VH
`define MARGIN_DAC_MAP_VH

`define ADDR_CONTROL 8'h52
`define ADDR_CODE 8'h5a
`define ADDR_UPPER 8'h62
`define ADDR_LOWER 8'h6a

`define CTRL_ENABLE_BIT 2
`define CTRL_SELECT_HI 1
`define CTRL_SELECT_LO 0
`define CTRL_RESERVED 5'h00

`define RESET_CONTROL 3'h0
`define RESET_ENABLE 1'h0
`define RESET_SELECT 2'h0
`define CENTER_1V25 8'h7d
`define CENTER_1V00 8'h64
`define CENTER_0V80 8'h50
`define CENTER_0V60 8'h3c
`define RESET_CODE 8'h7f
`define RESET_UPPER 8'hff
`define RESET_LOWER 8'h00
`define CODE_MIDSCALE 8'h7f
`define READ_UNMAPPED 8'h00

`define SELECT_1V25 2'h0
`define SELECT_1V00 2'h1
`define SELECT_0V80 2'h2
`define SELECT_0V60 2'h3

`endif

//--- margin_code_clamp.v
`timescale 1ns/1ps
`default_nettype none
`include "margin_dac_map.vh"

module margin_code_clamp (
	input wire [7:0] rawCode,
	input wire [7:0] upperClamp,
	input wire [7:0] lowerClamp,
	input wire enableBit,
	output wire [7:0] clampedCode,
	output wire outputActive
);

	// The upper clamp is tested first; both only matter when the limits are consistent.
	assign clampedCode = (rawCode > upperClamp) ? upperClamp :
		((rawCode < lowerClamp) ? lowerClamp : rawCode);

	// Inverted limits force the output off so no code between them can be driven.
	assign outputActive = enableBit & ~(lowerClamp > upperClamp);

endmodule
`default_nettype wire

//--- margin_dac_channel_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "margin_dac_map.vh"

module margin_dac_channel_regs (
	input wire clk,
	input wire resetn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output wire [7:0] regRdData,
	output wire channelOutputEnable,
	output wire [1:0] centerVoltageSelect,
	output wire [7:0] effectiveCode,
	output wire [7:0] centerMillivolts
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state and next values.
	reg enable_ff;
	reg nxt_enable;
	reg [1:0] select_ff;
	reg [1:0] nxt_select;
	reg [7:0] code_ff;
	reg [7:0] nxt_code;
	reg [7:0] upper_ff;
	reg [7:0] nxt_upper;
	reg [7:0] lower_ff;
	reg [7:0] nxt_lower;

	// Output stage state and next values.
	reg [7:0] rdData_ff;
	reg [7:0] nxt_rdData;
	reg outEnable_ff;
	reg nxt_outEnable;
	reg [1:0] outSelect_ff;
	reg [1:0] nxt_outSelect;
	reg [7:0] outCode_ff;
	reg [7:0] nxt_outCode;
	reg [7:0] outCenter_ff;
	reg [7:0] nxt_outCenter;

	// Decoded write strobes.
	wire wrControl;
	wire wrCode;
	wire wrUpper;
	wire wrLower;

	// Decoded read strobes.
	wire rdControl;
	wire rdCode;
	wire rdUpper;
	wire rdLower;

	// Clamp results.
	wire [7:0] clampedCode;
	wire outputActive;

	////////////////////////////////////////////////////////////////////////////////
	// True when the bus address selects the given register offset.
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// Center voltage in units of 10 mV, so the four settings fit one byte.
	function [7:0] center_of;
		input [1:0] sel;
		begin
			case (sel)
				`SELECT_1V25: begin
					center_of = `CENTER_1V25;
				end
				`SELECT_1V00: begin
					center_of = `CENTER_1V00;
				end
				`SELECT_0V80: begin
					center_of = `CENTER_0V80;
				end
				`SELECT_0V60: begin
					center_of = `CENTER_0V60;
				end
				default: begin
					center_of = `CENTER_1V25;
				end
			endcase
		end
	endfunction

	// Control byte as software sees it: the reserved bits always read as zero.
	function [7:0] control_view;
		input en;
		input [1:0] sel;
		begin
			control_view = {`CTRL_RESERVED, en, sel};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Writes and reads share one decoder so the two views of the map cannot drift apart.
	assign wrControl = regWrStb & addr_hit(regAddr, `ADDR_CONTROL);
	assign wrCode = regWrStb & addr_hit(regAddr, `ADDR_CODE);
	assign wrUpper = regWrStb & addr_hit(regAddr, `ADDR_UPPER);
	assign wrLower = regWrStb & addr_hit(regAddr, `ADDR_LOWER);

	assign rdControl = regRdStb & addr_hit(regAddr, `ADDR_CONTROL);
	assign rdCode = regRdStb & addr_hit(regAddr, `ADDR_CODE);
	assign rdUpper = regRdStb & addr_hit(regAddr, `ADDR_UPPER);
	assign rdLower = regRdStb & addr_hit(regAddr, `ADDR_LOWER);

	////////////////////////////////////////////////////////////////////////////////
	// Control register. Bits above the enable bit are dropped on write.
	always @* begin
		nxt_enable = enable_ff;
		nxt_select = select_ff;
		if (wrControl) begin
			nxt_enable = regWrData[`CTRL_ENABLE_BIT];
			nxt_select = regWrData[`CTRL_SELECT_HI:`CTRL_SELECT_LO];
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enable_ff <= `RESET_ENABLE;
			select_ff <= `RESET_SELECT;
		end else begin
			enable_ff <= nxt_enable;
			select_ff <= nxt_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output code register, kept raw; clamping happens downstream.
	always @* begin
		nxt_code = code_ff;
		if (wrCode) begin
			nxt_code = regWrData;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			code_ff <= `RESET_CODE;
		end else begin
			code_ff <= nxt_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Upper clamp register. Reset wide open so a fresh channel is not clamped.
	always @* begin
		nxt_upper = upper_ff;
		if (wrUpper) begin
			nxt_upper = regWrData;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			upper_ff <= `RESET_UPPER;
		end else begin
			upper_ff <= nxt_upper;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lower clamp register.
	always @* begin
		nxt_lower = lower_ff;
		if (wrLower) begin
			nxt_lower = regWrData;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lower_ff <= `RESET_LOWER;
		end else begin
			lower_ff <= nxt_lower;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path. Reads return the raw written values, never the clamped code.
	always @* begin
		nxt_rdData = `READ_UNMAPPED;
		if (rdControl) begin
			nxt_rdData = control_view(enable_ff, select_ff);
		end else if (rdCode) begin
			nxt_rdData = code_ff;
		end else if (rdUpper) begin
			nxt_rdData = upper_ff;
		end else if (rdLower) begin
			nxt_rdData = lower_ff;
		end
	end

	// Read data is valid only in the cycle after the strobe; zero otherwise.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData_ff <= `READ_UNMAPPED;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	assign regRdData = rdData_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Clamping is combinational, so it follows every write to the code or a limit.
	margin_code_clamp u_clamp (
		.rawCode(code_ff),
		.upperClamp(upper_ff),
		.lowerClamp(lower_ff),
		.enableBit(enable_ff),
		.clampedCode(clampedCode),
		.outputActive(outputActive)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs follow the registers one cycle later, so any write is reflected then.
	// A disabled channel parks at midscale to avoid a stale level on re-enable.
	always @* begin
		nxt_outEnable = outputActive;
		nxt_outSelect = select_ff;
		nxt_outCenter = center_of(select_ff);
		nxt_outCode = `CODE_MIDSCALE;
		if (outputActive) begin
			nxt_outCode = clampedCode;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			outEnable_ff <= `RESET_ENABLE;
			outSelect_ff <= `SELECT_1V25;
			outCode_ff <= `CODE_MIDSCALE;
			outCenter_ff <= `CENTER_1V25;
		end else begin
			outEnable_ff <= nxt_outEnable;
			outSelect_ff <= nxt_outSelect;
			outCode_ff <= nxt_outCode;
			outCenter_ff <= nxt_outCenter;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every output comes straight from a flip-flop.
	assign channelOutputEnable = outEnable_ff;
	assign centerVoltageSelect = outSelect_ff;
	assign effectiveCode = outCode_ff;
	assign centerMillivolts = outCenter_ff;

endmodule
`default_nettype wire

//--- margin_dac_channel_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module margin_dac_channel_regs_assertions (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic channelOutputEnable,
	input wire logic [1:0] centerVoltageSelect,
	input wire logic [7:0] effectiveCode,
	input wire logic [7:0] centerMillivolts
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire ctlWr = regWrStb && regAddr == 8'h52;
	wire [7:0] mvOf = centerVoltageSelect[1] ? (centerVoltageSelect[0] ? 8'h3c : 8'h50) :
		(centerVoltageSelect[0] ? 8'h64 : 8'h7d);
	chk_read_idle_zero:
	assert property ($past(!regRdStb) |-> regRdData == 8'h00) else $error("idle read data");
	chk_ctrl_reserved:
	assert property ($past(regRdStb && regAddr == 8'h52) |-> regRdData[7:3] == 5'h00) else $error("rsv");
	chk_unmapped_read:
	assert property ($past(regRdStb && regAddr == 8'h55) |-> regRdData == 8'h00) else $error("unmapped");
	chk_park_code:
	assert property (!channelOutputEnable |-> effectiveCode == 8'h7f) else $error("park code");
	chk_center_map:
	assert property (centerMillivolts == mvOf) else $error("center voltage");
	chk_select_follows:
	assert property (ctlWr |=> ##1 centerVoltageSelect == $past(regWrData[1:0], 2)) else $error("sel");
	chk_disable_write:
	assert property (ctlWr && !regWrData[2] |=> ##1 !channelOutputEnable) else $error("enable");
	chk_outputs_hold:
	assert property (!$past(regWrStb, 2) |-> $stable(effectiveCode)) else $error("code moved");
	cover property (ctlWr);
	cover property (channelOutputEnable);
	cover property (regRdStb);
endmodule
`default_nettype wire

//--- tb_margin_dac_channel_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_margin_dac_channel_regs;
	logic clk = 1'h0, resetn = 1'h0, regWrStb = 1'h0, regRdStb = 1'h0, channelOutputEnable;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, effectiveCode, centerMillivolts;
	logic [1:0] centerVoltageSelect;
	logic [7:0] mvTab [4] = '{8'h7d, 8'h64, 8'h50, 8'h3c};
	int n_fail = 0, compares = 0;
	margin_dac_channel_regs dut_u (.*);
	initial forever #20 clk = ~clk;
	// Each write waits until the functional outputs have taken it.
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		{regAddr, regWrData, regWrStb} <= {a, d, 1'h1};
		@(posedge clk);
		regWrStb <= 1'h0;
		@(posedge clk);
		#1;
	endtask
	task rd(input logic [7:0] a, e, input string n);
		@(posedge clk);
		{regAddr, regRdStb} <= {a, 1'h1};
		@(posedge clk);
		regRdStb <= 1'h0;
		#1;
		`CHK(n, e, regRdData)
	endtask
	task t_regs;
		`CHK("park", 8'h7f, effectiveCode)
		`CHK("mv rst", 8'h7d, centerMillivolts)
		rd(8'h52, 8'h00, "ctrl rst");
		rd(8'h5a, 8'h7f, "code rst");
		rd(8'h62, 8'hff, "upper rst");
		rd(8'h6a, 8'h00, "lower rst");
		wr(8'h52, 8'hfe);
		rd(8'h52, 8'h06, "ctrl");
		wr(8'h55, 8'h33);
		rd(8'h55, 8'h00, "unmapped");
		$display("t_regs done");
	endtask
	task t_sel;
		for (int i = 0; i < 4; i++) begin
			wr(8'h52, 8'h04 | 8'(i));
			`CHK("sel", 2'(i), centerVoltageSelect)
			`CHK("mv", mvTab[i], centerMillivolts)
		end
		$display("t_sel done");
	endtask
	task t_reset;
		wr(8'h52, 8'h04);
		@(posedge clk);
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		#1;
		`CHK("rst enable", 1'h0, channelOutputEnable)
		`CHK("rst code", 8'h7f, effectiveCode)
		rd(8'h5a, 8'h7f, "rst raw");
		$display("t_reset done");
	endtask
	task t_clamp;
		wr(8'h62, 8'h90);
		wr(8'h6a, 8'h20);
		wr(8'h5a, 8'ha5);
		`CHK("upper", 8'h90, effectiveCode)
		wr(8'h5a, 8'h10);
		`CHK("lower", 8'h20, effectiveCode)
		rd(8'h5a, 8'h10, "raw");
		rd(8'h62, 8'h90, "upper raw");
		wr(8'h6a, 8'h95);
		`CHK("interlock", 1'h0, channelOutputEnable)
		`CHK("parked", 8'h7f, effectiveCode)
		rd(8'h6a, 8'h95, "lower raw");
		wr(8'h6a, 8'h20);
		`CHK("on", 1'h1, channelOutputEnable)
		wr(8'h52, 8'h00);
		`CHK("off", 1'h0, channelOutputEnable)
		$display("t_clamp done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		t_regs;
		t_sel;
		t_clamp;
		t_reset;
		close_out;
	end
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		close_out;
	end
endmodule
bind margin_dac_channel_regs margin_dac_channel_regs_assertions chk_u (.*);
`default_nettype wire
